// ### rtl/cscbt_regs.svh
// Constants of the CPU-space cycle and bus termination controller
`ifndef CSCBT_REGS_SVH
`define CSCBT_REGS_SVH
`define CSCBT_CPU_SPACE 3'h7
`define CSCBT_TYPE_DEBUG_BREAK_INPUT 4'h0
`define CSCBT_TYPE_LOW_POWER_STOP_INSTRUCTION 4'h3
`define CSCBT_TYPE_IACK 4'hF
`define CSCBT_LOW_POWER_STOP_INSTRUCTION_ADDR 20'h3FFFE
`define CSCBT_DEBUG_BREAK_INPUT_PAD 11'h000
`define CSCBT_HW_DEBUG_BREAK_INPUT_NUM 3'h7
`define CSCBT_SW_MARK 1'h0
`define CSCBT_HW_MARK 1'h1
`define CSCBT_ZERO_BIT 1'h0
`define CSCBT_MASK_PAD 13'h0000
`define CSCBT_PORT8_ACK 2'h2
`define CSCBT_BYTE_STEP 20'h00001
`endif

// ### rtl/cscbt_pkg.sv
// Types of the CPU-space cycle and bus termination controller
`default_nettype none
package cscbt_pkg;
	typedef enum logic [1:0] {kind_read, kind_write, kind_swbk, kind_lps} cscbt_kind_type;
	typedef enum logic [2:0] {st_idle, st_assert, st_wait, st_late, st_fast, st_pause, st_retry,
		st_stop} cscbt_phase_type;
	typedef enum logic [2:0] {term_none, term_normal, term_pause, term_check, term_fault,
		term_retry} cscbt_term_type;
	typedef struct packed {
		logic tagged_insn;
		logic operand_hit;
		logic request;
	} cscbt_track_state_type;
	typedef struct packed {
		cscbt_phase_type state;
		cscbt_kind_type kind;
		logic hw;
		logic [2:0] space;
		logic [19:0] addr;
		logic rw;
		logic [15:0] wdata;
		logic as_on;
		logic ds_on;
		logic drive;
		logic [15:0] cap;
		logic port8;
		logic second;
		logic resume;
		logic [15:0] rdata;
		logic done;
		logic fault;
		logic insert_valid;
		logic [15:0] word;
		logic exc_valid;
		logic [7:0] vector;
		logic lps;
		logic [2:0] mask;
	} cscbt_ctrl_state_type;
endpackage
`default_nettype wire

// ### rtl/cscbt_term_decode.sv
// Classifies acknowledge, bus fault and pause into a termination kind
`default_nettype none
module cscbt_term_decode
(
	input wire logic late,
	input wire logic [1:0] size_acknowledge_n,
	input wire logic autovector_acknowledge_n,
	input wire logic bus_fault_in_n,
	input wire logic pause_in_n,
	output var logic ack,
	output var cscbt_pkg::cscbt_term_type term
);
	import cscbt_pkg::*;
	always_comb
	begin
		ack = !(&size_acknowledge_n) || !autovector_acknowledge_n;
		term = term_none;
		if (!bus_fault_in_n && !pause_in_n)
			term = term_retry;
		else if (!bus_fault_in_n)
			term = term_fault;
		else if (late)
			term = term_normal;
		else if (ack && !pause_in_n)
			term = term_pause;
		else if (ack)
			term = term_check;
	end
endmodule
`default_nettype wire

// ### rtl/cscbt_debug_break_input_track.sv
// Holds hardware breakpoint hits until the instruction they belong to ends
`default_nettype none
module cscbt_debug_break_input_track
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic debug_break_input_n,
	input wire logic fetch_active,
	input wire logic fetch_is_prefetch,
	input wire logic pipe_flush,
	input wire logic insn_end,
	input wire logic taken,
	output logic request
);
	import cscbt_pkg::*;
	cscbt_track_state_type st;
	cscbt_track_state_type next_st;
	logic hit;
	assign hit = !debug_break_input_n && fetch_active;
	assign request = st.request;
	always_comb
	begin
		next_st = st;
		if (taken)
			next_st.request = 1'h0;
		if (pipe_flush)
			next_st.tagged_insn = 1'h0;
		if (insn_end && (st.tagged_insn || st.operand_hit))
		begin
			next_st.request = 1'h1;
			next_st.tagged_insn = 1'h0;
			next_st.operand_hit = 1'h0;
		end
		if (hit && fetch_is_prefetch)
			next_st.tagged_insn = 1'h1;
		if (hit && !fetch_is_prefetch)
			next_st.operand_hit = 1'h1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end
endmodule
`default_nettype wire

// ### rtl/cscbt_bus_ctrl.sv
// Bus cycle controller for CPU-space cycles and cycle termination
`include "cscbt_regs.svh"
`default_nettype none
module cscbt_bus_ctrl
#(
	parameter logic [7:0] ILLEGAL_VECTOR = 8'h01,
	parameter logic [7:0] HW_DEBUG_BREAK_INPUT_VECTOR = 8'h02
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire cscbt_pkg::cscbt_kind_type req_kind,
	input wire logic [2:0] req_space,
	input wire logic [19:0] req_addr,
	input wire logic [15:0] req_wdata,
	input wire logic [2:0] req_opcode_low,
	input wire logic [2:0] req_mask,
	output logic req_ready,
	output logic core_done,
	output logic core_fault,
	output logic [15:0] core_rdata,
	input wire logic fetch_active,
	input wire logic fetch_is_prefetch,
	input wire logic pipe_flush,
	input wire logic insn_end,
	output logic insn_insert_valid,
	output logic [15:0] insn_insert_word,
	output logic exc_valid,
	output logic [7:0] exc_vector,
	input wire logic [2:0] irq_level,
	input wire logic bus_granted_away,
	output logic low_power_stop,
	output logic [2:0] clock_mask,
	output logic [2:0] address_space_code,
	output logic [19:0] address_bus,
	output logic read_write,
	output logic address_strobe_n,
	output logic data_strobe_n,
	output logic [15:0] data_out,
	output logic data_oe,
	input wire logic [15:0] data_in,
	input wire logic [1:0] size_acknowledge_n,
	input wire logic autovector_acknowledge_n,
	input wire logic bus_fault_in_n,
	input wire logic pause_in_n,
	input wire logic debug_break_input_n
);
	import cscbt_pkg::*;

	cscbt_ctrl_state_type st;
	cscbt_ctrl_state_type next_st;
	cscbt_term_type term;
	logic ack;
	logic track_request;
	logic track_taken;
	logic fin;
	logic fin_fault;
	logic fin_pause;
	logic rerun;

	cscbt_term_decode u_term
	(
		.late(st.state == st_late),
		.size_acknowledge_n(size_acknowledge_n),
		.autovector_acknowledge_n(autovector_acknowledge_n),
		.bus_fault_in_n(bus_fault_in_n),
		.pause_in_n(pause_in_n),
		.ack(ack),
		.term(term)
	);

	cscbt_debug_break_input_track u_track
	(
		.ref_clk(ref_clk),
		.resetn(resetn),
		.debug_break_input_n(debug_break_input_n),
		.fetch_active(fetch_active),
		.fetch_is_prefetch(fetch_is_prefetch),
		.pipe_flush(pipe_flush),
		.insn_end(insn_end),
		.taken(track_taken),
		.request(track_request)
	);

	// Hardware breakpoint acknowledge wins over a waiting core request
	assign req_ready = (st.state == st_idle) && !track_request;
	assign track_taken = (st.state == st_idle) && track_request;

	assign address_space_code = st.space;
	assign address_bus = st.addr;
	assign read_write = st.rw;
	assign address_strobe_n = !st.as_on;
	assign data_strobe_n = !st.ds_on;
	assign data_out = st.wdata;
	assign data_oe = st.drive;
	assign core_done = st.done;
	assign core_fault = st.fault;
	assign core_rdata = st.rdata;
	assign insn_insert_valid = st.insert_valid;
	assign insn_insert_word = st.word;
	assign exc_valid = st.exc_valid;
	assign exc_vector = st.vector;
	assign low_power_stop = st.lps;
	assign clock_mask = st.mask;

	always_comb
	begin
		next_st = st;
		fin = 1'h0;
		fin_fault = 1'h0;
		fin_pause = 1'h0;
		rerun = 1'h0;
		next_st.done = 1'h0;
		next_st.fault = 1'h0;
		next_st.insert_valid = 1'h0;
		next_st.exc_valid = 1'h0;
		case (st.state)
		st_idle:
		begin
			if (track_request)
			begin
				next_st.hw = 1'h1;
				next_st.space = `CSCBT_CPU_SPACE;
				next_st.addr = {`CSCBT_TYPE_DEBUG_BREAK_INPUT, `CSCBT_DEBUG_BREAK_INPUT_PAD, `CSCBT_HW_DEBUG_BREAK_INPUT_NUM,
					`CSCBT_HW_MARK, `CSCBT_ZERO_BIT};
				next_st.rw = 1'h1;
				next_st.second = 1'h0;
				next_st.resume = 1'h0;
				next_st.as_on = 1'h1;
				next_st.ds_on = 1'h1;
				next_st.drive = 1'h0;
				next_st.state = st_assert;
			end
			else if (req_valid)
			begin
				next_st.kind = req_kind;
				next_st.hw = 1'h0;
				next_st.second = 1'h0;
				next_st.resume = 1'h0;
				next_st.space = req_space;
				next_st.addr = req_addr;
				next_st.rw = (req_kind == kind_read);
				next_st.wdata = req_wdata;
				if (req_kind == kind_swbk)
				begin
					next_st.space = `CSCBT_CPU_SPACE;
					next_st.addr = {`CSCBT_TYPE_DEBUG_BREAK_INPUT, `CSCBT_DEBUG_BREAK_INPUT_PAD, req_opcode_low,
						`CSCBT_SW_MARK, `CSCBT_ZERO_BIT};
					next_st.rw = 1'h1;
				end
				else if (req_kind == kind_lps)
				begin
					next_st.space = `CSCBT_CPU_SPACE;
					next_st.addr = `CSCBT_LOW_POWER_STOP_INSTRUCTION_ADDR;
					next_st.rw = 1'h0;
					next_st.wdata = {`CSCBT_MASK_PAD, req_mask};
				end
				if ((req_kind == kind_lps) && bus_granted_away)
				begin
					// Stop entered without showing the broadcast
					next_st.mask = req_mask;
					next_st.lps = 1'h1;
					next_st.done = 1'h1;
					next_st.state = st_stop;
				end
				else
				begin
					next_st.as_on = 1'h1;
					next_st.ds_on = (req_kind == kind_read) || (req_kind == kind_swbk);
					next_st.drive = (req_kind == kind_write) || (req_kind == kind_lps);
					next_st.state = st_assert;
				end
			end
		end
		st_assert:
		begin
			if (!st.hw && (st.kind == kind_lps))
				next_st.state = st_fast;
			else
			begin
				next_st.ds_on = 1'h1;
				next_st.state = st_wait;
			end
		end
		st_fast:
		begin
			// Internal acknowledge; fault and pause pins are not looked at
			next_st.mask = st.wdata[2:0];
			next_st.lps = 1'h1;
			next_st.done = 1'h1;
			next_st.as_on = 1'h0;
			next_st.drive = 1'h0;
			next_st.state = st_stop;
		end
		st_wait:
		begin
			if (ack)
			begin
				next_st.cap = data_in;
				next_st.port8 = (size_acknowledge_n == `CSCBT_PORT8_ACK);
			end
			case (term)
			term_retry:
				rerun = 1'h1;
			term_fault:
			begin
				fin = 1'h1;
				fin_fault = 1'h1;
			end
			term_pause:
			begin
				fin = 1'h1;
				fin_pause = 1'h1;
			end
			term_check:
				next_st.state = st_late;
			default:
				next_st.state = st_wait;
			endcase
		end
		st_late:
		begin
			// Fault one state after the acknowledge still counts
			case (term)
			term_retry:
				rerun = 1'h1;
			term_fault:
			begin
				fin = 1'h1;
				fin_fault = 1'h1;
			end
			default:
				fin = 1'h1;
			endcase
		end
		st_retry:
		begin
			if (bus_fault_in_n && pause_in_n)
			begin
				next_st.as_on = 1'h1;
				next_st.ds_on = st.rw;
				next_st.drive = !st.rw;
				next_st.state = st_assert;
			end
		end
		st_pause:
		begin
			if (pause_in_n)
			begin
				next_st.state = st.resume ? st_retry : st_idle;
				next_st.resume = 1'h0;
			end
		end
		st_stop:
		begin
			if (irq_level > st.mask)
			begin
				next_st.lps = 1'h0;
				next_st.state = st_idle;
			end
		end
		default:
			next_st.state = st_idle;
		endcase
		if (rerun)
		begin
			next_st.as_on = 1'h0;
			next_st.ds_on = 1'h0;
			next_st.drive = 1'h0;
			next_st.state = st_retry;
		end
		if (fin)
		begin
			next_st.as_on = 1'h0;
			next_st.ds_on = 1'h0;
			next_st.drive = 1'h0;
			next_st.state = fin_pause ? st_pause : st_idle;
			if (st.hw)
			begin
				next_st.hw = 1'h0;
				if (fin_fault)
				begin
					next_st.exc_valid = 1'h1;
					next_st.vector = HW_DEBUG_BREAK_INPUT_VECTOR;
				end
			end
			else if (st.kind == kind_swbk)
			begin
				if (fin_fault)
				begin
					next_st.exc_valid = 1'h1;
					next_st.vector = ILLEGAL_VECTOR;
					next_st.done = 1'h1;
				end
				else if (next_st.port8 && !st.second)
				begin
					// First byte of an 8-bit port; fetch the other half
					next_st.word = {next_st.cap[15:8], next_st.cap[7:0]};
					next_st.second = 1'h1;
					next_st.addr = st.addr + `CSCBT_BYTE_STEP;
					next_st.resume = 1'h1;
					next_st.state = fin_pause ? st_pause : st_retry;
				end
				else
				begin
					next_st.insert_valid = 1'h1;
					next_st.word = st.second ? {st.word[15:8], next_st.cap[15:8]} : next_st.cap;
					next_st.done = 1'h1;
				end
			end
			else
			begin
				next_st.done = 1'h1;
				next_st.fault = fin_fault;
				next_st.rdata = next_st.cap;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence lps_entry;
		(st.state == st_assert) && !st.hw && (st.kind == kind_lps);
	endsequence

	sequence lps_fast_end;
		(!address_strobe_n && data_strobe_n) ##1 (low_power_stop && address_strobe_n);
	endsequence

	sequence retry_blocked;
		(st.state == st_retry) && (!bus_fault_in_n || !pause_in_n);
	endsequence

	a_cpu_space_code: assert property (
		(!address_strobe_n && (st.hw || (st.kind == kind_swbk) || (st.kind == kind_lps)))
		|-> (address_space_code == `CSCBT_CPU_SPACE))
		else $error("CPU-space cycle without space code 7");

	a_cpu_type_field: assert property (
		(!address_strobe_n && (address_space_code == `CSCBT_CPU_SPACE) && st.hw)
		|-> (address_bus[19:16] == `CSCBT_TYPE_DEBUG_BREAK_INPUT))
		else $error("Breakpoint acknowledge with wrong access type");

	a_sw_debug_break_input_addr: assert property (
		(!address_strobe_n && !st.hw && (st.kind == kind_swbk))
		|-> ((address_bus[19:16] == `CSCBT_TYPE_DEBUG_BREAK_INPUT) && read_write
		&& (st.second || (address_bus[1] == `CSCBT_SW_MARK))))
		else $error("Software breakpoint acknowledge address wrong");

	a_hw_debug_break_input_addr: assert property (
		(!address_strobe_n && st.hw) |-> ((address_bus[4:2] == `CSCBT_HW_DEBUG_BREAK_INPUT_NUM)
		&& (address_bus[1] == `CSCBT_HW_MARK) && read_write))
		else $error("Hardware breakpoint acknowledge address wrong");

	a_insert_source: assert property (
		insn_insert_valid |-> (($past(st.state) == st_late) && !exc_valid && core_done))
		else $error("Instruction inserted outside an acknowledged breakpoint");

	a_illegal_exc: assert property (
		((st.state == st_wait) && !st.hw && (st.kind == kind_swbk) && (term == term_fault))
		|=> (exc_valid && (exc_vector == ILLEGAL_VECTOR) && !insn_insert_valid))
		else $error("Faulted software breakpoint did not raise illegal exception");

	a_hw_ack_ignored: assert property (
		(st.hw && (st.state == st_late) && (term == term_normal))
		|=> (!exc_valid && !insn_insert_valid && (st.state == st_idle)))
		else $error("Acknowledged hardware breakpoint was not ignored");

	a_low_power_stop_instruction_data: assert property (
		(!address_strobe_n && !st.hw && (st.kind == kind_lps))
		|-> (data_oe && (data_out[15:3] == `CSCBT_MASK_PAD)
		&& (address_bus == `CSCBT_LOW_POWER_STOP_INSTRUCTION_ADDR) && !read_write))
		else $error("Low-power broadcast data or address wrong");

	a_low_power_stop_instruction_fast: assert property (
		lps_entry |=> lps_fast_end)
		else $error("Low-power broadcast did not end with fast timing");

	a_low_power_stop_instruction_nofault: assert property (
		(st.state == st_fast) |=> (!core_fault && low_power_stop && !exc_valid))
		else $error("Bus fault acted on the low-power broadcast");

	a_low_power_stop_instruction_hidden: assert property (
		(req_valid && req_ready && (req_kind == kind_lps) && bus_granted_away)
		|=> (address_strobe_n && low_power_stop && core_done) ##1 address_strobe_n)
		else $error("Low-power broadcast shown while bus granted away");

	a_stop_wake: assert property (
		((st.state == st_stop) && (irq_level > clock_mask))
		|=> (!low_power_stop && (st.state == st_idle)))
		else $error("Stop mode not left on higher interrupt");

	a_pause_hold: assert property (
		((st.state == st_pause) && !pause_in_n) |=> (address_strobe_n && !core_done))
		else $error("Bus activity while paused");

	a_fault_end: assert property (
		((st.state == st_wait) && !st.hw && (st.kind == kind_read) && (term == term_fault))
		|=> (core_done && core_fault && address_strobe_n))
		else $error("Bus fault did not end the read with an error");

	a_retry_hold: assert property (
		retry_blocked |=> (address_strobe_n && !core_done))
		else $error("Cycle restarted while fault or pause held");

	a_retry_restart: assert property (
		((st.state == st_retry) && bus_fault_in_n && pause_in_n)
		|=> ((st.state == st_assert) && !address_strobe_n && $stable(address_bus)))
		else $error("Retried cycle changed address or did not start");
endmodule
`default_nettype wire

// ### dv/cscbt_far_end.sv
// Model of the external memories and breakpoint logic on the bus
`default_nettype none
module cscbt_far_end
(
	input wire logic ref_clk,
	input wire logic [2:0] address_space_code,
	input wire logic [19:0] address_bus,
	input wire logic read_write,
	input wire logic address_strobe_n,
	input wire logic [15:0] data_out,
	input wire logic data_oe,
	input wire logic [2:0] mode,
	input wire logic [15:0] word,
	output var logic [15:0] data_in,
	output var logic [1:0] size_acknowledge_n,
	output var logic autovector_acknowledge_n,
	output var logic bus_fault_in_n,
	output var logic pause_in_n,
	output var int n_cycles,
	output var int n_viol,
	output var logic [19:0] last_addr,
	output var logic [2:0] last_fc,
	output var logic [15:0] last_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	int hold;
	logic retried;
	initial
	begin
		{size_acknowledge_n, autovector_acknowledge_n, bus_fault_in_n, pause_in_n} = 5'h1F;
		data_in = 16'h0000;
		{n_cycles, n_viol, cnt, hold, retried} = '0;
	end
	// Modes: 0 ack, 1 fault, 2 retry once, 3 ack with pause, 4 byte port, 5 late fault,
	// 6 autovector acknowledge only
	task automatic answer();
		if (mode == 3'h1 || (mode == 3'h2 && !retried))
		begin
			bus_fault_in_n = 1'b0;
			pause_in_n = (mode == 3'h1);
			retried = (mode == 3'h2);
			hold = (mode == 3'h2) ? 2 : 0;
		end
		else
		begin
			size_acknowledge_n = (mode == 3'h4) ? 2'h2 : ((mode == 3'h6) ? 2'h3 : 2'h0);
			autovector_acknowledge_n = (mode != 3'h6);
			data_in = word;
			if (mode == 3'h4)
				data_in = {address_bus[0] ? word[7:0] : word[15:8], 8'h5A};
			if (mode == 3'h3)
			begin
				pause_in_n = 1'b0;
				hold = 4;
			end
		end
	endtask
	always @(posedge ref_clk)
	begin
		#1;
		if (mode != 3'h2)
			retried = 1'b0;
		if (!address_strobe_n)
		begin
			if (cnt == 0)
			begin
				n_cycles++;
				last_addr = address_bus;
				last_fc = address_space_code;
				if (!pause_in_n)
					n_viol++;
			end
			if (!read_write && data_oe)
				last_wdata = data_out;
			cnt++;
			if (cnt == 1)
				answer();
			if (cnt == 2 && mode == 3'h5)
				bus_fault_in_n = 1'b0;
		end
		else
		begin
			// Released lines must not keep the last value
			cnt = 0;
			size_acknowledge_n = 2'h3;
			autovector_acknowledge_n = 1'b1;
			data_in = ~data_in;
			if (hold > 0)
				hold--;
			else
			begin
				bus_fault_in_n = 1'b1;
				pause_in_n = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/cscbt_bus_ctrl_tb.sv
// Self-checking bench of the CPU-space cycle and bus termination controller
`default_nettype none
module cscbt_bus_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cscbt_pkg::*;
	cscbt_kind_type req_kind;
	logic ref_clk, resetn, req_valid, req_ready, core_done, core_fault, insn_insert_valid;
	logic [2:0] req_space, req_opcode_low, req_mask, irq_level, clock_mask, address_space_code;
	logic [2:0] mode, last_fc;
	logic [19:0] req_addr, address_bus, last_addr;
	logic [15:0] req_wdata, core_rdata, insn_insert_word, data_out, data_in, word, last_wdata;
	logic fetch_active, fetch_is_prefetch, pipe_flush, insn_end, exc_valid, bus_granted_away;
	logic low_power_stop, read_write, address_strobe_n, data_strobe_n, data_oe, pause_in_n;
	logic autovector_acknowledge_n, bus_fault_in_n, debug_break_input_n;
	logic [1:0] size_acknowledge_n;
	logic [7:0] exc_vector;
	logic s_done, s_fault, s_ins, s_exc;
	int n_errors = 0;
	int samples_checked = 0;
	int ticks = 0;
	int n_cycles, n_viol, n0, lat;
	cscbt_bus_ctrl dut
	(
		.ref_clk, .resetn, .req_valid, .req_kind, .req_space, .req_addr, .req_wdata,
		.req_opcode_low, .req_mask, .req_ready, .core_done, .core_fault, .core_rdata,
		.fetch_active, .fetch_is_prefetch, .pipe_flush, .insn_end, .insn_insert_valid,
		.insn_insert_word, .exc_valid, .exc_vector, .irq_level, .bus_granted_away,
		.low_power_stop, .clock_mask, .address_space_code, .address_bus, .read_write,
		.address_strobe_n, .data_strobe_n, .data_out, .data_oe, .data_in, .size_acknowledge_n,
		.autovector_acknowledge_n, .bus_fault_in_n, .pause_in_n, .debug_break_input_n
	);
	cscbt_far_end far
	(
		.ref_clk, .address_space_code, .address_bus, .read_write, .address_strobe_n,
		.data_out, .data_oe, .mode, .word, .data_in, .size_acknowledge_n,
		.autovector_acknowledge_n, .bus_fault_in_n, .pause_in_n, .n_cycles, .n_viol,
		.last_addr, .last_fc, .last_wdata
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		ticks++;
		if (ticks == 5000)
		begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Advance cycles, catching every one-cycle pulse
	task automatic step(input int n);
		repeat (n)
		begin
			@(posedge ref_clk);
			#1;
			{s_done, s_fault, s_ins, s_exc} |= {core_done, core_fault, insn_insert_valid, exc_valid};
		end
	endtask
	task automatic run(input cscbt_kind_type k, input logic [19:0] a, input logic [2:0] v);
		int i;
		{s_done, s_fault, s_ins, s_exc} = 4'h0;
		req_kind = k;
		req_space = v;
		req_opcode_low = v;
		req_mask = v;
		req_addr = a;
		req_wdata = word;
		req_valid = 1'b1;
		for (i = 0; i < 50 && !req_ready; i++)
			step(1);
		step(1);
		req_valid = 1'b0;
		// Cycle of done, with the taking cycle counted as 1
		for (lat = 2; lat < 61; lat++)
		begin
			step(1);
			if (s_done)
				break;
		end
	endtask
	task automatic t_read_write();
		word = 16'hC3A5;
		run(kind_read, 20'h12344, 3'h5);
		chk(lat, 4);
		chk(s_fault, 0);
		chk(core_rdata, 16'hC3A5);
		chk(last_fc, 5);
		word = 16'h5A0F;
		run(kind_write, 20'h0ABC0, 3'h1);
		chk(last_wdata, 16'h5A0F);
		mode = 3'h6;
		word = 16'h77E1;
		run(kind_read, 20'h00300, 3'h2);
		chk({s_fault, lat, core_rdata}, {1'b0, 32'h4, 16'h77E1});
		$display("read and write done");
	endtask
	task automatic t_fault();
		mode = 3'h1;
		run(kind_read, 20'h00100, 3'h1);
		chk(s_fault, 1);
		mode = 3'h5;
		run(kind_write, 20'h00200, 3'h1);
		chk(s_fault, 1);
		$display("bus fault done");
	endtask
	task automatic t_retry_pause();
		mode = 3'h2;
		n0 = n_cycles;
		run(kind_write, 20'h0F0F0, 3'h2);
		chk(n_cycles - n0, 2);
		chk({s_fault, last_addr, last_wdata}, {1'b0, 20'h0F0F0, word});
		mode = 3'h3;
		run(kind_read, 20'h00040, 3'h1);
		mode = 3'h0;
		run(kind_read, 20'h00042, 3'h1);
		chk(n_viol, 0);
		chk(s_fault, 0);
		$display("retry and pause done");
	endtask
	task automatic t_soft_break();
		word = 16'h4E71;
		run(kind_swbk, 20'h00000, 3'h5);
		chk({last_fc, last_addr}, {3'h7, 20'h00014});
		chk({s_ins, insn_insert_word}, {1'b1, 16'h4E71});
		mode = 3'h4;
		word = 16'hB2C7;
		n0 = n_cycles;
		run(kind_swbk, 20'h00000, 3'h2);
		chk(n_cycles - n0, 2);
		chk(last_addr, 20'h00009);
		chk(insn_insert_word, 16'hB2C7);
		mode = 3'h1;
		run(kind_swbk, 20'h00000, 3'h3);
		chk({s_exc, exc_vector}, {1'b1, 8'h01});
		$display("software breakpoint done");
	endtask
	task automatic hw(input logic pre, input logic flush);
		{s_done, s_fault, s_ins, s_exc} = 4'h0;
		fetch_active = 1'b1;
		fetch_is_prefetch = pre;
		debug_break_input_n = 1'b0;
		step(1);
		fetch_active = 1'b0;
		debug_break_input_n = 1'b1;
		pipe_flush = flush;
		step(1);
		pipe_flush = 1'b0;
		insn_end = 1'b1;
		step(1);
		insn_end = 1'b0;
		step(12);
	endtask
	task automatic t_hard_break();
		n0 = n_cycles;
		hw(1'b0, 1'b0);
		chk(n_cycles - n0, 1);
		chk({last_fc, last_addr}, {3'h7, 20'h0001E});
		chk({s_exc, exc_vector, s_done}, {1'b1, 8'h02, 1'b0});
		mode = 3'h0;
		hw(1'b1, 1'b0);
		chk(n_cycles - n0, 2);
		chk(s_exc, 0);
		hw(1'b1, 1'b1);
		chk(n_cycles - n0, 2);
		$display("hardware breakpoint done");
	endtask
	task automatic t_stop();
		bus_granted_away = 1'b1;
		mode = 3'h1;
		n0 = n_cycles;
		run(kind_lps, 20'h00000, 3'h4);
		chk(n_cycles - n0, 0);
		chk({low_power_stop, clock_mask}, {1'b1, 3'h4});
		irq_level = 3'h4;
		step(2);
		chk(low_power_stop, 1);
		irq_level = 3'h5;
		step(2);
		chk(low_power_stop, 0);
		irq_level = 3'h0;
		bus_granted_away = 1'b0;
		run(kind_lps, 20'h00000, 3'h6);
		chk(lat, 3);
		chk({last_fc, last_addr}, {3'h7, 20'h3FFFE});
		chk(last_wdata, 16'h0006);
		chk(low_power_stop, 1);
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		step(1);
		chk(low_power_stop, 0);
		$display("low-power stop done");
	endtask
	initial
	begin
		{resetn, req_valid, fetch_active, fetch_is_prefetch, pipe_flush, insn_end} = '0;
		{bus_granted_away, irq_level, mode, word} = '0;
		req_kind = kind_read;
		{req_space, req_opcode_low, req_mask, req_addr, req_wdata} = '0;
		debug_break_input_n = 1'b1;
		repeat (20) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		t_read_write();
		t_fault();
		t_retry_pause();
		t_soft_break();
		t_hard_break();
		t_stop();
		print_verdict();
	end
endmodule
`default_nettype wire
